// ===== iwcb_pkg.sv
package iwcb_pkg;
  // Instruction word layout.
  localparam logic [7:0] IWCB_PREFIX = 8'h78;
  localparam int IWCB_MODE_HI = 15;
  localparam int IWCB_MODE_LO = 14;
  localparam logic [1:0] IWCB_MODE_IR = 2'h0;
  localparam logic [1:0] IWCB_MODE_EA = 2'h1;
  localparam logic [1:0] IWCB_MODE_REG = 2'h2;
  localparam logic [1:0] IWCB_SIZE_B = 2'h0;
  localparam logic [1:0] IWCB_SIZE_W = 2'h2;
  localparam logic [1:0] IWCB_SIZE_L = 2'h3;
  localparam int IWCB_DST_HI = 5;
  localparam int IWCB_DST_LO = 4;
  localparam int IWCB_SIGNED_BIT = 0;
  localparam int IWCB_EXT_MAX = 3;
  // Register map.
  localparam logic [7:0] IWCB_OP_CTRL = 8'h00;
  localparam logic [7:0] IWCB_OP_WORD0 = 8'h04;
  localparam logic [7:0] IWCB_OP_WORD1 = 8'h08;
  localparam logic [7:0] IWCB_OP_SRC = 8'h0C;
  localparam logic [7:0] IWCB_OP_RESULT = 8'h10;
  localparam logic [7:0] IWCB_OP_FLAGS = 8'h14;
  localparam logic [7:0] IWCB_OP_IRQ_STAT = 8'h18;
  localparam logic [7:0] IWCB_OP_IRQ_MASK = 8'h1C;
  // Control register fields.
  localparam int IWCB_CTRL_GO_CVT = 0;
  localparam int IWCB_CTRL_GO_DAB = 1;
  localparam int IWCB_CTRL_CARRY = 2;
  localparam int IWCB_CTRL_NIBBLE = 3;
  localparam int IWCB_CTRL_SUB = 4;
  // Flag register fields.
  localparam int IWCB_FLG_V = 0;
  localparam int IWCB_FLG_S = 1;
  localparam int IWCB_FLG_C = 2;
  localparam int IWCB_FLG_TRAP = 3;
  localparam int IWCB_FLG_BADOP = 4;
  // Interrupt status fields.
  localparam int IWCB_IRQ_DONE = 0;
  localparam int IWCB_IRQ_TRAP = 1;
  localparam int IWCB_IRQ_BADOP = 2;
  localparam int IWCB_IRQ_W = 3;
  // Decimal correction values and bus response codes.
  localparam logic [7:0] IWCB_ADJ_LO = 8'h06;
  localparam logic [7:0] IWCB_ADJ_HI = 8'h60;
  localparam logic [7:0] IWCB_ADJ_SUB_LO = 8'hFA;
  localparam logic [7:0] IWCB_ADJ_SUB_HI = 8'hA0;
  localparam logic [3:0] IWCB_NIB_NINE = 4'h9;
  localparam logic [1:0] IWCB_RESP_OK = 2'h0;
  localparam logic [1:0] IWCB_RESP_SLVERR = 2'h2;
endpackage

// ===== iwcb_conv_unit.sv
`timescale 1ns/1ns
module iwcb_conv_unit
  import iwcb_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Request.
  input wire logic start_i,
  input wire logic is_signed_i,
  input wire logic [1:0] dst_size_i,
  input wire logic [1:0] src_size_i,
  input wire logic [31:0] src_i,
  // Result.
  output logic [31:0] result_o,
  output logic wrap_o,
  output logic neg_o,
  output logic valid_o
);
  logic [31:0] result_r, result_nxt;
  logic wrap_r, wrap_nxt, neg_r, neg_nxt, valid_r, valid_nxt;
  logic [31:0] ext;
  logic [31:0] cut;

  // ==========================================================
  // Resize datapath.
  always_comb
  begin
    ext = src_i;
    case (src_size_i)
      IWCB_SIZE_B: ext = is_signed_i ? {{24{src_i[7]}}, src_i[7:0]}
                                     : {24'h0, src_i[7:0]};
      IWCB_SIZE_W: ext = is_signed_i ? {{16{src_i[15]}}, src_i[15:0]}
                                     : {16'h0, src_i[15:0]};
      default: ext = src_i;
    endcase
    cut = ext;
    wrap_nxt = 1'b0;
    case (dst_size_i)
      IWCB_SIZE_B:
      begin
        cut = {24'h0, ext[7:0]};
        wrap_nxt = is_signed_i ? (ext[31:7] != {25{ext[7]}})
                               : (ext[31:8] != 24'h0);
      end
      IWCB_SIZE_W:
      begin
        cut = {16'h0, ext[15:0]};
        wrap_nxt = is_signed_i ? (ext[31:15] != {17{ext[15]}})
                               : (ext[31:16] != 16'h0);
      end
      default: cut = ext;
    endcase
    neg_nxt = (dst_size_i == IWCB_SIZE_B) ? cut[7] :
              (dst_size_i == IWCB_SIZE_W) ? cut[15] : cut[31];
    result_nxt = start_i ? cut : result_r;
    if (!start_i)
    begin
      wrap_nxt = wrap_r;
      neg_nxt = neg_r;
    end
    valid_nxt = start_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      result_r <= 32'h0;
      wrap_r <= 1'b0;
      neg_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else
    begin
      result_r <= result_nxt;
      wrap_r <= wrap_nxt;
      neg_r <= neg_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign result_o = result_r;
  assign wrap_o = wrap_r;
  assign neg_o = neg_r;
  assign valid_o = valid_r;
endmodule

// ===== iwcb_top.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
// Summary of operation
// - Convert reads source, resizes, writes result; source register untouched.
// - Signed widening copies the source sign into added upper bits.
// - Unsigned widening fills added upper bits with zeros.
// - Narrowing keeps low bits; wrap flag set when value not representable.
// - Signed to byte wraps outside -128..127; signed forms may trap.
// - Signed long to word wraps outside -32768..32767.
// - Unsigned long to word wraps above 65535.
// - Negative flag equals the top bit of the stored result.
// - Convert recognised by prefix byte 01111000 then an operation word.
// - Mode bits 10 register, 00 indirect, 01 effective address plus extensions.
// - Decimal adjust leaves two valid BCD digits after byte add/subtract.
// - Correction chosen from operation, carry, nibble carry and nibble values.
// - Add correction is 00, 06, 60 or 66; carry set for 60/66.
module iwcb_top
  import iwcb_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // AXI4-Lite write address.
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address.
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Status outputs.
  output logic irq_o,
  output logic overflow_trap_o
);
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [4:0] ctrl_r, ctrl_nxt;
  logic [31:0] word0_r, word0_nxt, word1_r, word1_nxt, src_r, src_nxt;
  logic [31:0] res_r, res_nxt;
  logic [4:0] flags_r, flags_nxt;
  logic [IWCB_IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic irq_r, irq_nxt, trap_r, trap_nxt;
  logic [1:0] ext_cnt_r, ext_cnt_nxt;
  logic pend_r, pend_nxt;
  logic do_write;
  logic [31:0] wmask;
  logic [IWCB_IRQ_W-1:0] ev;
  logic cvt_go, dab_go, op_ok, is_signed;
  logic [1:0] dst_size, src_size, mode;
  logic [31:0] cu_result;
  logic cu_wrap, cu_neg, cu_valid;
  logic [7:0] dab_corr, dab_val;
  logic dab_carry;
  logic [3:0] nib_hi, nib_lo;

  // ==========================================================
  // Instruction decode.
  always_comb
  begin
    mode = word1_r[IWCB_MODE_HI:IWCB_MODE_LO];
    is_signed = word0_r[IWCB_SIGNED_BIT];
    dst_size = word0_r[IWCB_DST_HI:IWCB_DST_LO];
    src_size = (word1_r[5:0] == 6'h21 || word1_r[5:0] == 6'h2E) ? IWCB_SIZE_W :
               (word1_r[5:0] == 6'h14 || word1_r[5:0] == 6'h1D ||
                word1_r[5:0] == 6'h2F) ? IWCB_SIZE_L : IWCB_SIZE_B;
    op_ok = (word0_r[15:8] == IWCB_PREFIX) &&
            (dst_size != src_size) &&
            (dst_size != 2'h1) && (mode != 2'h3);
  end

  // ==========================================================
  // Width conversion unit.
  assign cvt_go = pend_r && (ext_cnt_r == 2'h0) && op_ok;
  iwcb_conv_unit u_conv
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(cvt_go),
    .is_signed_i(is_signed),
    .dst_size_i(dst_size),
    .src_size_i(src_size),
    .src_i(src_r),
    .result_o(cu_result),
    .wrap_o(cu_wrap),
    .neg_o(cu_neg),
    .valid_o(cu_valid)
  );

  // ==========================================================
  // Decimal adjust.
  always_comb
  begin
    nib_hi = src_r[7:4];
    nib_lo = src_r[3:0];
    dab_corr = 8'h00;
    dab_carry = ctrl_r[IWCB_CTRL_CARRY];
    if (!ctrl_r[IWCB_CTRL_SUB])
    begin
      if (ctrl_r[IWCB_CTRL_NIBBLE] || nib_lo > IWCB_NIB_NINE)
        dab_corr = IWCB_ADJ_LO;
      if (ctrl_r[IWCB_CTRL_CARRY] || nib_hi > IWCB_NIB_NINE ||
          (nib_hi == IWCB_NIB_NINE && nib_lo > IWCB_NIB_NINE))
        dab_corr = dab_corr | IWCB_ADJ_HI;
      dab_carry = dab_corr[6];
    end
    else
    begin
      if (ctrl_r[IWCB_CTRL_NIBBLE])
        dab_corr = IWCB_ADJ_SUB_LO;
      if (ctrl_r[IWCB_CTRL_CARRY])
        dab_corr = dab_corr + IWCB_ADJ_SUB_HI;
    end
    dab_val = src_r[7:0] + dab_corr;
  end
  assign dab_go = ctrl_r[IWCB_CTRL_GO_DAB];

  // ==========================================================
  // Register bus.
  always_comb
  begin
    do_write = aw_got_r && w_got_r && !bvalid_r;
    wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}},
             {8{wstrb_r[0]}}};
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    if (s_axi_awvalid_i && !aw_got_r)
    begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_got_r)
    begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata_i;
      wstrb_nxt = s_axi_wstrb_i;
    end
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (bvalid_r && s_axi_bready_i)
    begin
      bvalid_nxt = 1'b0;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
    end
    if (do_write)
    begin
      bvalid_nxt = 1'b1;
      bresp_nxt = (awaddr_r > IWCB_OP_IRQ_MASK || awaddr_r[1:0] != 2'h0) ?
                  IWCB_RESP_SLVERR : IWCB_RESP_OK;
    end
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rvalid_r && s_axi_rready_i)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid_i && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = IWCB_RESP_OK;
      case (s_axi_araddr_i)
        IWCB_OP_CTRL: rdata_nxt = {27'h0, ctrl_r};
        IWCB_OP_WORD0: rdata_nxt = word0_r;
        IWCB_OP_WORD1: rdata_nxt = word1_r;
        IWCB_OP_SRC: rdata_nxt = src_r;
        IWCB_OP_RESULT: rdata_nxt = res_r;
        IWCB_OP_FLAGS: rdata_nxt = {25'h0, pend_r, ext_cnt_r == 2'h0,
                                    flags_r};
        IWCB_OP_IRQ_STAT: rdata_nxt = {29'h0, stat_r};
        IWCB_OP_IRQ_MASK: rdata_nxt = {29'h0, mask_r};
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = IWCB_RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================
  // Control, operands, result and interrupts.
  always_comb
  begin
    ctrl_nxt = ctrl_r & ~5'h3;
    word0_nxt = word0_r;
    word1_nxt = word1_r;
    src_nxt = src_r;
    mask_nxt = mask_r;
    pend_nxt = pend_r;
    ext_cnt_nxt = ext_cnt_r;
    ev = '0;
    stat_nxt = stat_r;
    if (do_write)
      case (awaddr_r)
        IWCB_OP_CTRL: ctrl_nxt = (ctrl_r & ~wmask[4:0]) |
                                 (wdata_r[4:0] & wmask[4:0]);
        IWCB_OP_WORD0: word0_nxt = (word0_r & ~wmask) | (wdata_r & wmask);
        IWCB_OP_WORD1:
        begin
          word1_nxt = (word1_r & ~wmask) | (wdata_r & wmask);
          ext_cnt_nxt = (wdata_r[IWCB_MODE_HI:IWCB_MODE_LO] == IWCB_MODE_EA)
                        ? wdata_r[17:16] : 2'h0;
        end
        IWCB_OP_SRC:
        begin
          src_nxt = (src_r & ~wmask) | (wdata_r & wmask);
          if (ext_cnt_r != 2'h0)
            ext_cnt_nxt = ext_cnt_r - 2'h1;
        end
        IWCB_OP_IRQ_STAT: stat_nxt = stat_r & ~wdata_r[IWCB_IRQ_W-1:0];
        IWCB_OP_IRQ_MASK: mask_nxt = wdata_r[IWCB_IRQ_W-1:0];
        default: ;
      endcase
    if (ctrl_r[IWCB_CTRL_GO_CVT])
      pend_nxt = 1'b1;
    res_nxt = res_r;
    flags_nxt = flags_r;
    trap_nxt = 1'b0;
    if (pend_r && ext_cnt_r == 2'h0)
    begin
      pend_nxt = 1'b0;
      if (!op_ok)
      begin
        flags_nxt[IWCB_FLG_BADOP] = 1'b1;
        ev[IWCB_IRQ_BADOP] = 1'b1;
      end
    end
    if (cu_valid)
    begin
      res_nxt = cu_result;
      flags_nxt[IWCB_FLG_V] = cu_wrap;
      flags_nxt[IWCB_FLG_S] = cu_neg;
      flags_nxt[IWCB_FLG_BADOP] = 1'b0;
      flags_nxt[IWCB_FLG_TRAP] = cu_wrap && is_signed;
      trap_nxt = cu_wrap && is_signed;
      ev[IWCB_IRQ_DONE] = 1'b1;
      ev[IWCB_IRQ_TRAP] = cu_wrap && is_signed;
    end
    if (dab_go)
    begin
      res_nxt = {24'h0, dab_val};
      flags_nxt[IWCB_FLG_C] = dab_carry;
      flags_nxt[IWCB_FLG_S] = dab_val[7];
      ev[IWCB_IRQ_DONE] = 1'b1;
    end
    stat_nxt = stat_nxt | ev;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0;
      ctrl_r <= 5'h0;
      word0_r <= 32'h0;
      word1_r <= 32'h0;
      src_r <= 32'h0;
      res_r <= 32'h0;
      flags_r <= 5'h0;
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
      trap_r <= 1'b0;
      ext_cnt_r <= 2'h0;
      pend_r <= 1'b0;
    end
    else
    begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      word0_r <= word0_nxt;
      word1_r <= word1_nxt;
      src_r <= src_nxt;
      res_r <= res_nxt;
      flags_r <= flags_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      trap_r <= trap_nxt;
      ext_cnt_r <= ext_cnt_nxt;
      pend_r <= pend_nxt;
    end
  end

  assign s_axi_awready_o = !aw_got_r;
  assign s_axi_wready_o = !w_got_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o = rresp_r;
  assign s_axi_rdata_o = rdata_r;
  assign irq_o = irq_r;
  assign overflow_trap_o = trap_r;
endmodule

// ===== iwcb_top_monitor.sv
`timescale 1ns/1ns
module iwcb_top_monitor
  import iwcb_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Bus handshakes.
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Status.
  input wire logic irq_o,
  input wire logic overflow_trap_o
);
  // ==========================================================
  // Bus and status properties.
  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  chk_write_answer:
    assert property (wr_take |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response missing");
  chk_read_answer:
    assert property (rd_take |-> ##[1:2] s_axi_rvalid_o)
    else $error("read response missing");
  chk_bvalid_hold:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  chk_rvalid_hold:
    assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  chk_write_once:
    assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  chk_read_once:
    assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read response repeated");
  chk_read_block:
    assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address open during response");
  chk_write_block:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write open during response");
  chk_trap_pulse:
    assert property (overflow_trap_o |=> !overflow_trap_o)
    else $error("trap longer than one cycle");
  chk_reset_idle:
    assert property ($fell(rst_i) |-> s_axi_awready_o && s_axi_arready_o &&
      !s_axi_bvalid_o && !irq_o && !overflow_trap_o)
    else $error("outputs not idle after reset");
endmodule

bind iwcb_top iwcb_top_monitor u_mon (
  .core_clk_i(core_clk_i), .rst_i(rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .irq_o(irq_o), .overflow_trap_o(overflow_trap_o)
);

// ===== iwcb_op_feeder.sv
`timescale 1ns/1ns
module iwcb_op_feeder
(
  // Clock.
  input wire logic core_clk_i,
  // Write side.
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // Read side.
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // ==========================================================
  // Bus requests; lag delays each response handshake.
  integer lag = 0;
  initial
  begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic ad;
    logic wd;
    awaddr_o <= a;
    wdata_o <= d;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= (lag == 0);
    ad = 1'b0;
    wd = 1'b0;
    do
    begin
      @(posedge core_clk_i);
      ad = ad | awready_i;
      wd = wd | wready_i;
      awvalid_o <= !ad;
      wvalid_o <= !wd;
    end
    while (!(ad && wd));
    repeat (lag) @(posedge core_clk_i);
    bready_o <= 1'b1;
    do @(posedge core_clk_i); while (!bvalid_i);
    r = bresp_i;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= (lag == 0);
    do @(posedge core_clk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    repeat (lag) @(posedge core_clk_i);
    rready_o <= 1'b1;
    do @(posedge core_clk_i); while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
  endtask
endmodule

// ===== iwcb_tb_top.sv
`timescale 1ns/1ns
module iwcb_tb_top;
  import iwcb_pkg::*;
  logic core_clk_i;
  logic rst_i;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, msk;
  logic arvalid, arready, rvalid, rready, irq, trap;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [1:0] sz [3];
  logic [31:0] vals [12] = '{32'h7F, 32'h80, 32'hFFFFFF80, 32'hFFFFFF7F,
    32'h7FFF, 32'h8000, 32'hFFFF8000, 32'hFFFF7FFF, 32'hFF, 32'h100,
    32'hFFFF, 32'h10000};
  integer miscompares = 0;
  integer n_compared = 0;
  integer seed = 32'h7fec;
  integer cyc = 0;
  integer n_trap = 0;
  integer i, j, r;
  // ==========================================================
  // Design and partner.
  iwcb_top DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .irq_o(irq), .overflow_trap_o(trap)
  );
  iwcb_op_feeder u_feed (
    .core_clk_i(core_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
    .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
    .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready)
  );
  // ==========================================================
  // Clock, timeout and checking.
  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    cyc = cyc + 1;
    n_trap = n_trap + (trap === 1'b1);
    if (cyc == 40000)
    begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Conversion with its reference model.
  task automatic signed_width_convert(input logic sg, input logic [1:0] ds,
    input logic [1:0] ss, input logic [31:0] v, input logic bp);
    longint s, lim;
    integer sb, db, ext, t0, k;
    logic [31:0] m, ex, pr;
    logic w, bad, tr;
    sb = (ss == IWCB_SIZE_B) ? 8 : (ss == IWCB_SIZE_W) ? 16 : 32;
    db = (ds == IWCB_SIZE_B) ? 8 : (ds == IWCB_SIZE_W) ? 16 : 32;
    s = v & ((64'h1 << sb) - 1);
    if (sg && s[sb-1])
      s = s - (64'sh1 << sb);
    lim = 64'sh1 << (db - 1);
    w = sg ? (s >= lim || s < -lim) : (s >= (64'sh1 << db));
    m = 32'((64'h1 << db) - 1);
    ex = s[31:0] & m;
    bad = bp || ds == ss;
    tr = !bad && sg && w;
    ext = $random(seed) & 3;
    u_feed.wr(IWCB_OP_RESULT, 0, rs);
    u_feed.rd(IWCB_OP_RESULT, pr, rs);
    u_feed.wr(IWCB_OP_WORD0, {16'h0, bp ? 8'h79 : IWCB_PREFIX, 2'h0, ds,
      3'h0, sg}, rs);
    u_feed.wr(IWCB_OP_WORD1, {14'h0, ext[1:0], (ext != 0) ? IWCB_MODE_EA :
      (v[1] ? IWCB_MODE_REG : IWCB_MODE_IR), 8'h0, (sb == 8) ? 6'h20 :
      (sb == 16) ? 6'h21 : 6'h14}, rs);
    repeat ((ext != 0) ? ext : 1) u_feed.wr(IWCB_OP_SRC, v, rs);
    t0 = n_trap;
    u_feed.wr(IWCB_OP_CTRL, 32'h1, rs);
    k = 0;
    do
    begin
      u_feed.rd(IWCB_OP_IRQ_STAT, rd, rs);
      k = k + 1;
    end
    while (rd[2:0] == 3'h0 && k < 20);
    chk("badop", 32'(bad), 32'(rd[2]));
    if (!bad)
      chk("stat", {30'h0, tr, 1'b1}, {30'h0, rd[1:0]});
    chk("irq", 32'(msk), 32'(irq));
    chk("trap", 32'(tr), n_trap - t0);
    u_feed.rd(IWCB_OP_RESULT, rd, rs);
    chk("result", bad ? pr & m : ex, rd & m);
    u_feed.rd(IWCB_OP_FLAGS, rd, rs);
    if (!bad)
      chk("wrap", 32'(w), 32'(rd[0]));
    if (!bad)
      chk("neg", 32'(ex[db-1]), 32'(rd[1]));
    u_feed.rd(IWCB_OP_SRC, rd, rs);
    chk("src", v, rd);
    u_feed.wr(IWCB_OP_IRQ_STAT, 32'h7, rs);
    repeat (2) @(posedge core_clk_i);
    chk("irq clear", 0, 32'(irq));
  endtask
  // ==========================================================
  // Decimal adjust after a true BCD byte add or subtract.
  task automatic dab(input integer a, input integer b, input logic sb,
    input logic ci);
    integer ia, ib, x, e;
    logic h, c;
    ia = a / 10 * 16 + a % 10;
    ib = b / 10 * 16 + b % 10;
    x = sb ? ia - ib - ci : ia + ib + ci;
    h = sb ? (ia % 16 < ib % 16 + ci) : (ia % 16 + ib % 16 + ci > 15);
    c = sb ? x < 0 : x > 255;
    e = sb ? a - b - ci : a + b + ci;
    u_feed.wr(IWCB_OP_SRC, {24'h0, x[7:0]}, rs);
    u_feed.wr(IWCB_OP_CTRL, {27'h0, sb, h, c, 2'h2}, rs);
    repeat (2) @(posedge core_clk_i);
    u_feed.rd(IWCB_OP_RESULT, rd, rs);
    x = (e + 100) % 100;
    chk("bcd", x / 10 * 16 + x % 10, {24'h0, rd[7:0]});
    u_feed.rd(IWCB_OP_FLAGS, rd, rs);
    chk("carry", 32'(sb ? e < 0 : e > 99), 32'(rd[2]));
  endtask
  // ==========================================================
  // Main sequence.
  initial
  begin
    sz = '{IWCB_SIZE_B, IWCB_SIZE_W, IWCB_SIZE_L};
    rst_i = 1'b1;
    msk = 1'b0;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    u_feed.rd(IWCB_OP_CTRL, rd, rs);
    chk("ctrl reset", 0, rd);
    u_feed.rd(8'h20, rd, rs);
    chk("unmapped rresp", 32'(IWCB_RESP_SLVERR), 32'(rs));
    chk("unmapped rdata", 0, rd);
    u_feed.wr(8'h24, 32'h1, rs);
    chk("unmapped bresp", 32'(IWCB_RESP_SLVERR), 32'(rs));
    u_feed.wr(IWCB_OP_IRQ_MASK, 32'h0, rs);
    signed_width_convert(1'b1, IWCB_SIZE_B, IWCB_SIZE_L, 32'h80, 1'b0);
    u_feed.wr(IWCB_OP_IRQ_MASK, 32'h7, rs);
    msk = 1'b1;
    signed_width_convert(1'b1, IWCB_SIZE_W, IWCB_SIZE_B, 32'h81, 1'b1);
    for (i = 0; i < 12; i = i + 1)
      for (j = 0; j < 6; j = j + 1)
        signed_width_convert(j[0], sz[j/2], IWCB_SIZE_L, vals[i], 1'b0);
    repeat (60)
    begin
      r = $random(seed);
      u_feed.lag = r[9:8];
      signed_width_convert(r[0], sz[r[3:0] % 3], sz[r[7:4] % 3], $random(seed), 1'b0);
    end
    repeat (40)
    begin
      r = $random(seed);
      u_feed.lag = r[19:18];
      dab(r[6:0] % 100, r[14:8] % 100, r[16], r[17]);
    end
    wrap_up();
  end
endmodule
